// *** rtl/ppac_ctrl_top.sv ***
// Control of an eight-channel modulator: prescaled clocks A and B,
// per-channel alignment, pair joining and wait/freeze gating.
// Assumes an Avalon-MM master on the bus clock, word addressed, and
// channel enables plus wait/freeze levels synchronous to CORE_CLK.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module ppac_ctrl_top
	import ppac_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic [7:0]  CHANNEL_ENABLE,
	input  wire logic        WAIT_MODE,
	input  wire logic        FREEZE_MODE,
	output logic             CLK_A_EN,
	output logic             CLK_B_EN,
	output logic      [7:0]  CHAN_CENTER,
	output logic      [7:0]  CHAN_RUN,
	output logic      [3:0]  CHAN_JOIN
);

	////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		ppac_cfg_t  cfg;
		logic       ack;
		logic [7:0] rdata;
	} ppac_top_st_t;

	ppac_top_st_t     st_r;
	ppac_top_st_t     st_nxt;
	logic             req;
	logic             take;
	logic             pre_run;
	logic [PRE_W-1:0] pre_count;
	logic             tick_a;
	logic             tick_b;
	ppac_chan_t       chan;

	////////////////////////////////////////////////////////////////////
	// Register images, reserved bits forced to zero

	function automatic logic [7:0] reg_image(
		input ppac_top_st_t s,
		input logic [5:0]   idx,
		input logic         run,
		input logic [PRE_W-1:0] cnt
	);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			IDX_PRESCALE: begin
				v[SEL_A_LSB +: SEL_W] = s.cfg.clk_a_divider_sel;
				v[SEL_B_LSB +: SEL_W] = s.cfg.clk_b_divider_sel;
			end
			IDX_ALIGN: begin
				v = s.cfg.center_align_bit;
			end
			IDX_CTRL: begin
				v[CTL_JOIN_LSB +: JOIN_W] = s.cfg.join_pair;
				v[CTL_WAIT_BIT]   = s.cfg.wait_stop_prescaler;
				v[CTL_FREEZE_BIT] = s.cfg.freeze_stop_prescaler;
			end
			IDX_STATUS: begin
				v = {cnt, run};
			end
			default: begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction : reg_image

	////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, then the answer

	// Request stalls one cycle; the edge after that completes it
	assign req             = AVS_READ || AVS_WRITE;
	assign AVS_WAITREQUEST = req && !st_r.ack;
	assign take            = req && st_r.ack;
	assign AVS_READDATA    = {24'h000000, st_r.rdata};

	// Bus access never depends on the prescaler, so freeze cannot lock
	// software out of the control register
	always_comb begin
		st_nxt     = st_r;
		st_nxt.ack = req && !st_r.ack;
		if (req && !st_r.ack)
			st_nxt.rdata = reg_image(st_r, AVS_ADDRESS, pre_run,
				pre_count);
		if (take && AVS_WRITE && AVS_BYTEENABLE[0]) begin
			unique case (AVS_ADDRESS)
				IDX_PRESCALE: begin
					// Masked bits simply never land
					st_nxt.cfg.clk_a_divider_sel =
						AVS_WRITEDATA[SEL_A_LSB +: SEL_W];
					st_nxt.cfg.clk_b_divider_sel =
						AVS_WRITEDATA[SEL_B_LSB +: SEL_W];
				end
				IDX_ALIGN: begin
					st_nxt.cfg.center_align_bit =
						AVS_WRITEDATA[7:0];
				end
				IDX_CTRL: begin
					// No interlock against enabled channels
					st_nxt.cfg.join_pair =
						AVS_WRITEDATA[CTL_JOIN_LSB +: JOIN_W];
					st_nxt.cfg.wait_stop_prescaler =
						AVS_WRITEDATA[CTL_WAIT_BIT];
					st_nxt.cfg.freeze_stop_prescaler =
						AVS_WRITEDATA[CTL_FREEZE_BIT];
				end
				default: begin
					st_nxt.cfg = st_r.cfg;
				end
			endcase
		end
	end

	// Reset values
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			st_r.ack   <= 1'b0;
			st_r.rdata <= 8'h00;
			st_r.cfg.clk_a_divider_sel <=
				PRESCALE_RST[SEL_A_LSB +: SEL_W];
			st_r.cfg.clk_b_divider_sel <=
				PRESCALE_RST[SEL_B_LSB +: SEL_W];
			st_r.cfg.center_align_bit <= ALIGN_RST;
			st_r.cfg.join_pair <= CTRL_RST[CTL_JOIN_LSB +: JOIN_W];
			st_r.cfg.wait_stop_prescaler <= CTRL_RST[CTL_WAIT_BIT];
			st_r.cfg.freeze_stop_prescaler <= CTRL_RST[CTL_FREEZE_BIT];
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Prescaler gating and datapath

	// Gate the counter's input: wait, freeze or all channels idle
	assign pre_run = (|CHANNEL_ENABLE)
		&& !(WAIT_MODE && st_r.cfg.wait_stop_prescaler)
		&& !(FREEZE_MODE && st_r.cfg.freeze_stop_prescaler);

	ppac_prescaler u_prescaler (
		.clk    (CORE_CLK),
		.rst    (SYS_RST),
		.run    (pre_run),
		.sel_a  (st_r.cfg.clk_a_divider_sel),
		.sel_b  (st_r.cfg.clk_b_divider_sel),
		.tick_a (tick_a),
		.tick_b (tick_b),
		.count  (pre_count)
	);

	ppac_pair_map u_pair_map (
		.clk    (CORE_CLK),
		.rst    (SYS_RST),
		.cfg    (st_r.cfg),
		.enable (CHANNEL_ENABLE),
		.chan   (chan)
	);

	// Clock A serves 0,1,4,5 and clock B 2,3,6,7 in the counters
	assign CLK_A_EN    = tick_a;
	assign CLK_B_EN    = tick_b;
	assign CHAN_CENTER = chan.center;
	assign CHAN_RUN    = chan.run;
	assign CHAN_JOIN   = chan.join_pair;

	////////////////////////////////////////////////////////////////////
	// Checks

	sequence bus_req_s;
		req && AVS_WAITREQUEST;
	endsequence

	sequence bus_done_s;
		!AVS_WAITREQUEST;
	endsequence

	property bus_answer_p;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		bus_req_s |=> bus_done_s;
	endproperty

	bus_answer_a: assert property (bus_answer_p)
		else $error("bus request not answered in one wait cycle");

	sel_write_a: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST)
		take && AVS_WRITE && AVS_BYTEENABLE[0]
			&& AVS_ADDRESS == IDX_PRESCALE
		|=> st_r.cfg.clk_a_divider_sel == $past(AVS_WRITEDATA[2:0])
			&& st_r.cfg.clk_b_divider_sel == $past(AVS_WRITEDATA[6:4]))
		else $error("prescale write not taken");

	prescale_zero_a: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST)
		take && AVS_READ && AVS_ADDRESS == IDX_PRESCALE
		|-> AVS_READDATA[3] == 1'b0 && AVS_READDATA[7] == 1'b0
			&& AVS_READDATA[31:8] == 24'h000000)
		else $error("reserved prescale bits not zero");

	ctrl_zero_a: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST)
		take && AVS_READ && AVS_ADDRESS == IDX_CTRL
		|-> AVS_READDATA[1:0] == 2'h0)
		else $error("reserved control bits not zero");

	join_bits_a: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST)
		take && AVS_WRITE && AVS_BYTEENABLE[0]
			&& AVS_ADDRESS == IDX_CTRL
		|=> st_r.cfg.join_pair == $past(AVS_WRITEDATA[7:4]) ##1
			CHAN_JOIN == st_r.cfg.join_pair)
		else $error("join bits misplaced");

	wait_gate_a: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST)
		WAIT_MODE && st_r.cfg.wait_stop_prescaler |=> !CLK_A_EN
			&& !CLK_B_EN)
		else $error("prescaler ran in wait with stop set");

	freeze_gate_a: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST)
		FREEZE_MODE && st_r.cfg.freeze_stop_prescaler |=>
			$stable(pre_count))
		else $error("prescaler ran in freeze with stop set");

	idle_stop_a: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST)
		CHANNEL_ENABLE == 8'h00 |-> !pre_run)
		else $error("prescaler ran with all channels off");

endmodule : ppac_ctrl_top

// *** rtl/ppac_pkg.sv ***
// Shared constants, carriers and helpers for the prescale, align and
// pair-join control of the eight-channel modulator.
// Assumes one bus clock and a synchronous, active-high reset.
package ppac_pkg;

	////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index
	localparam logic [5:0] IDX_PRESCALE = 6'h03;
	localparam logic [5:0] IDX_ALIGN    = 6'h04;
	localparam logic [5:0] IDX_CTRL     = 6'h05;
	localparam logic [5:0] IDX_STATUS   = 6'h20;

	// Field positions
	localparam int SEL_W          = 3;
	localparam int SEL_A_LSB      = 0;
	localparam int SEL_B_LSB      = 4;
	localparam int CTL_FREEZE_BIT = 2;
	localparam int CTL_WAIT_BIT   = 3;
	localparam int CTL_JOIN_LSB   = 4;
	localparam int JOIN_W         = 4;

	// Writable bits; the rest read as zero
	localparam logic [7:0] PRESCALE_MASK = 8'h77;
	localparam logic [7:0] CTRL_MASK     = 8'hfc;

	// Reset values
	localparam logic [7:0] PRESCALE_RST = 8'h00;
	localparam logic [7:0] ALIGN_RST    = 8'h00;
	localparam logic [7:0] CTRL_RST     = 8'h00;

	// Prescaler counter width: 2**7 is the largest division
	localparam int PRE_W = 7;

	////////////////////////////////////////////////////////////////////
	// Software configuration handed to the datapath
	typedef struct packed {
		logic [JOIN_W-1:0] join_pair;
		logic              wait_stop_prescaler;
		logic              freeze_stop_prescaler;
		logic [SEL_W-1:0]  clk_b_divider_sel;
		logic [SEL_W-1:0]  clk_a_divider_sel;
		logic [7:0]        center_align_bit;
	} ppac_cfg_t;

	// Per-channel controls handed to the channel counters
	typedef struct packed {
		logic [7:0]        center;
		logic [7:0]        run;
		logic [JOIN_W-1:0] join_pair;
	} ppac_chan_t;

	// Low bits of the counter that must all be one for a tick
	function automatic logic [PRE_W-1:0] div_mask(
		input logic [SEL_W-1:0] sel
	);
		logic [7:0] m;
		m = (8'h01 << sel) - 8'h01;
		return m[PRE_W-1:0];
	endfunction : div_mask

endpackage : ppac_pkg

// *** rtl/ppac_prescaler.sv ***
// Free-running bus-clock prescaler that yields clock A and clock B as
// one-cycle enables. Assumes run already carries all stop conditions.
`timescale 1ns/1ps
module ppac_prescaler
	import ppac_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [SEL_W-1:0] sel_a,
	input  wire logic [SEL_W-1:0] sel_b,
	output logic                  tick_a,
	output logic                  tick_b,
	output logic [PRE_W-1:0]      count
);

	typedef struct packed {
		logic [PRE_W-1:0] cnt;
		logic             a_en;
		logic             b_en;
	} ppac_pre_st_t;

	ppac_pre_st_t st_r;
	ppac_pre_st_t st_nxt;

	////////////////////////////////////////////////////////////////////
	// One counter feeds both rates, so A and B stay phase related
	always_comb begin
		st_nxt = st_r;
		st_nxt.a_en = 1'b0;
		st_nxt.b_en = 1'b0;
		if (run) begin
			st_nxt.cnt  = st_r.cnt + 1'b1;
			st_nxt.a_en = (st_r.cnt & div_mask(sel_a)) == div_mask(sel_a);
			st_nxt.b_en = (st_r.cnt & div_mask(sel_b)) == div_mask(sel_b);
		end
	end

	// Selects are used live: a change mid-pulse may bend one pulse
	always_ff @(posedge clk) begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tick_a = st_r.a_en;
	assign tick_b = st_r.b_en;
	assign count  = st_r.cnt;

	////////////////////////////////////////////////////////////////////
	// Checks
	clk_a_full_a: assert property (@(posedge clk) disable iff (rst)
		run && sel_a == 3'h0 |=> tick_a)
		else $error("clock A missing at full rate");

	clk_b_half_a: assert property (@(posedge clk) disable iff (rst)
		(run && sel_b == 3'h1) [*3] |-> tick_b != $past(tick_b))
		else $error("clock B not alternating at divide by two");

	stop_hold_a: assert property (@(posedge clk) disable iff (rst)
		!run |=> $stable(count) && !tick_a && !tick_b)
		else $error("prescaler moved while stopped");

endmodule : ppac_prescaler

// *** rtl/ppac_pair_map.sv ***
// Folds pair joining onto the per-channel enables and alignment bits.
// Assumes enables come from the enable register outside this block.
`timescale 1ns/1ps
module ppac_pair_map
	import ppac_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  ppac_cfg_t       cfg,
	input  wire logic [7:0] enable,
	output ppac_chan_t      chan
);

	ppac_chan_t st_r;
	ppac_chan_t st_nxt;

	////////////////////////////////////////////////////////////////////
	// Even channel is the high byte, odd the low byte and the pin
	always_comb begin
		st_nxt.join_pair = cfg.join_pair;
		st_nxt.center    = cfg.center_align_bit;
		st_nxt.run       = enable;
		for (int p = 0; p < JOIN_W; p++) begin
			if (cfg.join_pair[p]) begin
				// Odd channel's bits steer the whole 16-bit channel
				st_nxt.center[2*p]   = cfg.center_align_bit[2*p+1];
				st_nxt.run[2*p]      = 1'b0;
				st_nxt.run[2*p+1]    = enable[2*p+1];
			end
		end
	end

	// Registered so the counters see clean levels
	always_ff @(posedge clk) begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign chan = st_r;

	////////////////////////////////////////////////////////////////////
	// Checks
	join_enable_a: assert property (@(posedge clk) disable iff (rst)
		cfg.join_pair[0] |=> !chan.run[0] && chan.run[1] == $past(enable[1]))
		else $error("joined pair enable not taken from low channel");

	align_follow_a: assert property (@(posedge clk) disable iff (rst)
		cfg.join_pair[3] |=> chan.center[6] == chan.center[7])
		else $error("joined pair alignment split");

	align_plain_a: assert property (@(posedge clk) disable iff (rst)
		!cfg.join_pair[1] |=> chan.center[2] == $past(cfg.center_align_bit[2]))
		else $error("alignment bit not passed through");

endmodule : ppac_pair_map

// *** tb/ppac_ctrl_top_tb.sv ***
// Self-checking bench for the prescale, align and pair-join control.
// Assumes one wait state per bus access is possible but never counted on.
`timescale 1ns/1ps
module ppac_ctrl_top_tb
	import ppac_pkg::*;
;
	logic        core_clk;
	logic        sys_rst;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  channel_enable;
	logic        wait_mode;
	logic        freeze_mode;
	logic        clk_a_en;
	logic        clk_b_en;
	logic [7:0]  chan_center;
	logic [7:0]  chan_run;
	logic [3:0]  chan_join;
	int          miscompares;
	int          cmp_count;
	int          cycles;
	integer      seed;

	////////////////////////////////////////////////////////////////////
	// Device under test
	ppac_ctrl_top u_dut (
		.CORE_CLK        (core_clk),
		.SYS_RST         (sys_rst),
		.AVS_ADDRESS     (avs_address),
		.AVS_READ        (avs_read),
		.AVS_WRITE       (avs_write),
		.AVS_WRITEDATA   (avs_writedata),
		.AVS_BYTEENABLE  (avs_byteenable),
		.AVS_READDATA    (avs_readdata),
		.AVS_WAITREQUEST (avs_waitrequest),
		.CHANNEL_ENABLE  (channel_enable),
		.WAIT_MODE       (wait_mode),
		.FREEZE_MODE     (freeze_mode),
		.CLK_A_EN        (clk_a_en),
		.CLK_B_EN        (clk_b_en),
		.CHAN_CENTER     (chan_center),
		.CHAN_RUN        (chan_run),
		.CHAN_JOIN       (chan_join)
	);

	////////////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task automatic give_verdict;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_cnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			miscompares++;
			$display("ERROR %0t ticks %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt

	////////////////////////////////////////////////////////////////////
	// Bus master; entered just after a rising edge, leaves one edge idle
	task automatic bus_xfer(input logic wr, input logic [5:0] idx,
			input logic [7:0] d, input logic [3:0] be,
			output logic [31:0] rd);
		avs_address    <= idx;
		avs_writedata  <= {24'h000000, d};
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= !wr;
		// Request stands until the edge that sees waitrequest low
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge core_clk);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge core_clk);
	endtask : bus_xfer

	// Counts enable pulses over n cycles
	task automatic count_ticks(input int n, output int ca, output int cb);
		ca = 0;
		cb = 0;
		repeat (n) begin
			@(negedge core_clk);
			ca += (clk_a_en === 1'b1);
			cb += (clk_b_en === 1'b1);
		end
		@(posedge core_clk);
	endtask : count_ticks

	////////////////////////////////////////////////////////////////////
	// Expected per-channel controls for a join pattern
	function automatic logic [7:0] exp_run(input logic [7:0] en,
			input logic [3:0] jn);
		logic [7:0] r;
		r = en;
		for (int p = 0; p < 4; p++) begin
			if (jn[p]) begin
				r[2*p] = 1'b0;
			end
		end
		return r;
	endfunction : exp_run

	function automatic logic [7:0] exp_ctr(input logic [7:0] al,
			input logic [3:0] jn);
		logic [7:0] r;
		r = al;
		for (int p = 0; p < 4; p++) begin
			if (jn[p]) begin
				r[2*p] = al[2*p+1];
			end
		end
		return r;
	endfunction : exp_ctr

	////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the run needs well under 6000 cycles
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] rd;
		logic [7:0]  d;
		logic [7:0]  en;
		logic [7:0]  al;
		logic [3:0]  jn;
		int          ca;
		int          cb;
		int          exp;
		logic [7:0]  t_en[6] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h81, 8'h80};
		logic        t_wm[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		logic        t_fm[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		logic [7:0]  t_ct[6] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h0c, 8'h04};
		logic        t_go[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		seed = 97476;
		miscompares = 0;
		cmp_count = 0;
		cycles = 0;
		sys_rst = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		channel_enable = 8'h00;
		wait_mode = 1'b0;
		freeze_mode = 1'b0;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		// Reset contents, and an unmapped index that must read zero
		bus_xfer(1'b0, IDX_PRESCALE, 8'h00, 4'hf, rd);
		chk_val(rd, 32'h00000000);
		bus_xfer(1'b0, IDX_ALIGN, 8'h00, 4'hf, rd);
		chk_val(rd, 32'h00000000);
		bus_xfer(1'b0, IDX_CTRL, 8'h00, 4'hf, rd);
		chk_val(rd, 32'h00000000);
		bus_xfer(1'b0, 6'h07, 8'h00, 4'hf, rd);
		chk_val(rd, 32'h00000000);
		// Status: no channel ever enabled, so count and run are zero
		bus_xfer(1'b0, IDX_STATUS, 8'h00, 4'hf, rd);
		chk_val(rd, 32'h00000000);
		// Random write and read back; unused bits must stay zero
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 8'hff : 8'($random(seed));
			bus_xfer(1'b1, IDX_PRESCALE, d, 4'hf, rd);
			bus_xfer(1'b0, IDX_PRESCALE, 8'h00, 4'hf, rd);
			chk_val(rd, {24'h000000, d & 8'h77});
			bus_xfer(1'b1, IDX_ALIGN, d, 4'hf, rd);
			bus_xfer(1'b0, IDX_ALIGN, 8'h00, 4'hf, rd);
			chk_val(rd, {24'h000000, d});
			bus_xfer(1'b1, IDX_CTRL, d, 4'hf, rd);
			bus_xfer(1'b0, IDX_CTRL, 8'h00, 4'hf, rd);
			chk_val(rd, {24'h000000, d & 8'hfc});
		end
		// Low byte lane off: the write must not land
		bus_xfer(1'b1, IDX_ALIGN, ~d, 4'he, rd);
		bus_xfer(1'b0, IDX_ALIGN, 8'h00, 4'hf, rd);
		chk_val(rd, {24'h000000, d});
		bus_xfer(1'b1, IDX_CTRL, 8'h00, 4'hf, rd);
		// Every divider code on both clocks, changed on the fly
		channel_enable <= 8'h01;
		for (int i = 0; i < 8; i++) begin
			d = {1'b0, 3'(7 - i), 1'b0, 3'(i)};
			bus_xfer(1'b1, IDX_PRESCALE, d, 4'hf, rd);
			count_ticks(256, ca, cb);
			chk_cnt(ca, 256 >> i);
			chk_cnt(cb, 256 >> (7 - i));
		end
		// Stop conditions at the undivided rate
		bus_xfer(1'b1, IDX_PRESCALE, 8'h00, 4'hf, rd);
		for (int k = 0; k < 6; k++) begin
			bus_xfer(1'b1, IDX_CTRL, t_ct[k], 4'hf, rd);
			channel_enable <= t_en[k];
			wait_mode      <= t_wm[k];
			freeze_mode    <= t_fm[k];
			repeat (3) @(posedge core_clk);
			count_ticks(64, ca, cb);
			exp = t_go[k] ? 64 : 0;
			chk_cnt(ca, exp);
			chk_cnt(cb, exp);
			// Status run flag must agree with the gating
			bus_xfer(1'b0, IDX_STATUS, 8'h00, 4'hf, rd);
			chk_val(rd & 32'hffffff01, {31'h0, t_go[k]});
		end
		// Still frozen: software clears the stop bit and counting resumes
		bus_xfer(1'b1, IDX_CTRL, 8'h00, 4'hf, rd);
		bus_xfer(1'b0, IDX_CTRL, 8'h00, 4'hf, rd);
		chk_val(rd, 32'h00000000);
		count_ticks(64, ca, cb);
		chk_cnt(ca, 64);
		freeze_mode <= 1'b0;
		// Join patterns against enables and alignment
		for (int i = 0; i < 24; i++) begin
			en = (i == 0) ? 8'hff : 8'($random(seed));
			al = (i == 0) ? 8'haa : 8'($random(seed));
			jn = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($random(seed));
			// Channels off while alignment and join bits change
			channel_enable <= 8'h00;
			bus_xfer(1'b1, IDX_ALIGN, al, 4'hf, rd);
			bus_xfer(1'b1, IDX_CTRL, {jn, 4'h0}, 4'hf, rd);
			channel_enable <= en;
			repeat (3) @(posedge core_clk);
			@(negedge core_clk);
			chk_val({24'h000000, chan_run}, {24'h000000, exp_run(en, jn)});
			chk_val({24'h000000, chan_center}, {24'h000000, exp_ctr(al, jn)});
			chk_val({28'h0000000, chan_join}, {28'h0000000, jn});
			@(posedge core_clk);
		end
		give_verdict();
	end

endmodule : ppac_ctrl_top_tb
